// *** src/rsp_csr_bank.sv ***
// register bank of the serial port: identifiers, feature block, port control/status, maintenance interrupt
// Operation
// - local config base registers always read zero
// - writable small id, fixed all-ones large id
// - host id resets all ones, write once
// - component label fully writable, resets zero
// - feature header reads zero pointer, fixed id
// - 24-bit time-out values, low byte zero
// - bit 31 selects host or agent role
// - bit 30 request permit stored and output
// - sticky retry/error flags, write one clears
// - live halt and stuck states read only
// - unrecoverable error drops enables, sets flag
// - link ok, training reported; bit4 zero
// - lane capacity and trained width readable
// - lane override field, reserved codes refused
// - shutdown falling edge forces link reinit
// - transmit enable limits issue, resets one
// - receive enable limits accepted requests
// - error check off disables error handling
// - interrupt output from enabled set flags
// - port-write dropped when disabled or pending
// - window miss flags for writes, reads
// - separate interrupt enable register, resets zero
// - port-write accept enable resets one
`timescale 1ns/1ps
module rsp_csr_bank
    import rsp_csr_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst_n,
    input  wire rsp_req_t  reg_req,
    output rsp_resp_t      reg_resp,
    input  wire rsp_stat_t port_stat,
    output rsp_ctrl_t      port_ctrl,
    output logic           mnt_irq
);

    // all state of the bank
    typedef struct packed {
        logic [7:0]  small_id;        // small system id
        logic [15:0] host_id;         // initialising host id
        logic        host_locked;     // host id written once
        logic [31:0] label;           // component label
        logic [23:0] link_to;         // link time-out
        logic [23:0] resp_to;         // response time-out
        logic        host_role;       // host or agent
        logic        req_permit;      // request issue permit
        logic        discovered;      // discovered marker
        logic        out_rty_seen;    // sticky retry seen
        logic        out_err_seen;    // sticky output error
        logic        in_err_seen;     // sticky input error
        logic        fatal_err;       // sticky fatal error
        logic [2:0]  lane_ovr;        // lane override
        logic        shutdown;        // port shutdown
        logic        tx_en;           // transmit issue enable
        logic        rx_en;           // receive accept enable
        logic        chk_off;         // error checking off
        logic        multicast;       // multicast bit, stored only
        logic [6:0]  int_flags;       // maintenance interrupt flags
        logic [6:0]  int_en;          // interrupt enables
        logic        pw_accept;       // port-write accept enable
        logic        pw_pending;      // stored port-write not yet read
        logic        force_reinit;    // reinit pulse
        logic        pw_store;        // port-write store pulse
        logic        pw_drop;         // port-write drop pulse
        logic [31:0] rdata;           // read data
        logic        rvalid;          // read valid pulse
    } rsp_state_t;

    rsp_state_t state_reg;           // registered state
    rsp_state_t state_next;          // next state

    // write-one-to-clear with the event winning over the clear
    function automatic logic w1c(input logic cur, input logic evt, input logic clr);
        w1c = evt | (cur & ~clr);
    endfunction

    // address match used by both read and write decode
    function automatic logic hit(input logic [16:0] a, input logic [16:0] ofs);
        hit = (a == ofs);
    endfunction

    // read mux of the whole map
    function automatic logic [31:0] read_word(input rsp_state_t s, input rsp_stat_t st, input logic [16:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (hit(a, OFS_CFG_BASE0) || hit(a, OFS_CFG_BASE1)) begin
            d = 32'h0000_0000;
        end else if (hit(a, OFS_BASE_ID)) begin
            d = {8'h00, s.small_id, LARGE_ID_VALUE};
        end else if (hit(a, OFS_HOST_LOCK)) begin
            d = {16'h0000, s.host_id};
        end else if (hit(a, OFS_COMP_LABEL)) begin
            d = s.label;
        end else if (hit(a, OFS_FEAT_HDR)) begin
            d = {NEXT_BLOCK_PTR, FEATURE_BLOCK_ID};
        end else if (hit(a, OFS_LINK_TO)) begin
            d = {s.link_to, 8'h00};
        end else if (hit(a, OFS_RESP_TO)) begin
            d = {s.resp_to, 8'h00};
        end else if (hit(a, OFS_GEN_CTRL)) begin
            // role, permit and discovered marker, rest reserved
            d[GC_HOST]     = s.host_role;
            d[GC_PERMIT]   = s.req_permit;
            d[GC_DISCOVER] = s.discovered;
        end else if (hit(a, OFS_ERR_STAT)) begin
            // sticky flags from state, halt states live from the port
            d[ES_OUT_RTY_SEEN]  = s.out_rty_seen;
            d[ES_OUT_RTY_STUCK] = st.out_retry_stuck;
            d[ES_OUT_RTY_HALT]  = st.out_retry_halt;
            d[ES_OUT_ERR_SEEN]  = s.out_err_seen;
            d[ES_OUT_ERR_HALT]  = st.out_error_halt;
            d[ES_IN_RTY_HALT]   = st.in_retry_halt;
            d[ES_IN_ERR_SEEN]   = s.in_err_seen;
            d[ES_IN_ERR_HALT]   = st.in_error_halt;
            d[ES_FATAL]         = s.fatal_err;
            d[ES_LINK_OK]       = st.link_ok;
            d[ES_TRAINING]      = st.link_training;
        end else if (hit(a, OFS_LANE_CTRL)) begin
            // fixed capacity, live trained width, stored controls
            d[LC_CAP_LSB+:2]     = LANE_CAPACITY;
            d[LC_TRAINED_LSB+:3] = st.trained_width;
            d[LC_OVR_LSB+:3]     = s.lane_ovr;
            d[LC_SHUTDOWN]       = s.shutdown;
            d[LC_TX_EN]          = s.tx_en;
            d[LC_RX_EN]          = s.rx_en;
            d[LC_CHK_OFF]        = s.chk_off;
            d[LC_MULTICAST]      = s.multicast;
            d[LC_SERIAL]         = 1'b1;
        end else if (hit(a, OFS_INT_FLAGS)) begin
            d[6:0] = s.int_flags;
        end else if (hit(a, OFS_INT_ENABLE)) begin
            d[6:0] = s.int_en;
        end else if (hit(a, OFS_PW_CTRL)) begin
            d[PW_ACCEPT_BIT] = s.pw_accept;
        end
        read_word = d;
    endfunction

    // next-state logic
    always_comb begin
        logic        wr;         // write strobe
        logic [31:0] wd;         // write data
        logic [16:0] a;          // byte address
        logic        chk;        // error checking active
        logic [6:0]  evt;        // interrupt flag events
        logic [6:0]  clr;        // interrupt flag clears
        logic        accept_pw;  // port-write taken this cycle
        // request fields and defaults for every local
        wr = reg_req.wr;
        wd = reg_req.wdata;
        a  = reg_req.addr;
        chk = ~state_reg.chk_off;
        evt = 7'h00;
        clr = 7'h00;
        accept_pw = 1'b0;
        state_next = state_reg;
        // pulses last a single cycle
        state_next.force_reinit = 1'b0;
        state_next.pw_store     = 1'b0;
        state_next.pw_drop      = 1'b0;

        // register writes, one register per cycle
        // read-only and unmapped offsets fall through untouched
        if (wr && hit(a, OFS_BASE_ID)) begin
            state_next.small_id = wd[23:16];
        end else if (wr && hit(a, OFS_HOST_LOCK)) begin
            if (!state_reg.host_locked) begin
                state_next.host_id     = wd[15:0];
                state_next.host_locked = 1'b1;
            end
        end else if (wr && hit(a, OFS_COMP_LABEL)) begin
            state_next.label = wd;
        end else if (wr && hit(a, OFS_LINK_TO)) begin
            state_next.link_to = wd[31:8];
        end else if (wr && hit(a, OFS_RESP_TO)) begin
            state_next.resp_to = wd[31:8];
        end else if (wr && hit(a, OFS_GEN_CTRL)) begin
            state_next.host_role  = wd[GC_HOST];
            state_next.req_permit = wd[GC_PERMIT];
            state_next.discovered = wd[GC_DISCOVER];
        end else if (wr && hit(a, OFS_LANE_CTRL)) begin
            if (wd[LC_OVR_LSB+:3] == OVR_NONE || wd[LC_OVR_LSB+:3] == OVR_LANE0
                || wd[LC_OVR_LSB+:3] == OVR_LANE2) begin
                state_next.lane_ovr = wd[LC_OVR_LSB+:3];
            end
            state_next.shutdown  = wd[LC_SHUTDOWN];
            state_next.tx_en     = wd[LC_TX_EN];
            state_next.rx_en     = wd[LC_RX_EN];
            state_next.chk_off   = wd[LC_CHK_OFF];
            state_next.multicast = wd[LC_MULTICAST];
            // shutdown released: restart training from silence
            state_next.force_reinit = state_reg.shutdown & ~wd[LC_SHUTDOWN];
        end else if (wr && hit(a, OFS_INT_ENABLE)) begin
            state_next.int_en = wd[6:0] & MI_USED_MASK;
        end else if (wr && hit(a, OFS_PW_CTRL)) begin
            state_next.pw_accept = wd[PW_ACCEPT_BIT];
        end

        // sticky port error/status flags, error events ignored with checking off
        state_next.out_rty_seen = w1c(state_reg.out_rty_seen, port_stat.out_retry_evt,
                                      wr && hit(a, OFS_ERR_STAT) && wd[ES_OUT_RTY_SEEN]);
        state_next.out_err_seen = w1c(state_reg.out_err_seen, chk & port_stat.out_error_evt,
                                      wr && hit(a, OFS_ERR_STAT) && wd[ES_OUT_ERR_SEEN]);
        state_next.in_err_seen  = w1c(state_reg.in_err_seen, chk & port_stat.in_error_evt,
                                      wr && hit(a, OFS_ERR_STAT) && wd[ES_IN_ERR_SEEN]);
        state_next.fatal_err    = w1c(state_reg.fatal_err, chk & port_stat.fatal_evt,
                                      wr && hit(a, OFS_ERR_STAT) && wd[ES_FATAL]);
        // unrecoverable error shuts both directions, overriding a same-cycle write
        if (chk && port_stat.fatal_evt) begin
            state_next.tx_en = 1'b0;
            state_next.rx_en = 1'b0;
        end

        // port-write arrival: drop when not accepting or previous one unread
        // pending is tested before a same-cycle read-out clears it
        accept_pw = port_stat.pw_arrive & state_reg.pw_accept & ~state_reg.pw_pending;
        state_next.pw_store = accept_pw;
        state_next.pw_drop  = port_stat.pw_arrive & ~accept_pw;
        if (accept_pw) begin
            state_next.pw_pending = 1'b1;
        end else if (port_stat.pw_read_done) begin
            state_next.pw_pending = 1'b0;
        end

        // maintenance interrupt flags
        evt = 7'h00;
        evt[MI_PW_ERROR]   = port_stat.pw_error_evt;
        evt[MI_PW_DROPPED] = port_stat.pw_arrive & ~accept_pw;
        evt[MI_PW_STORED]  = accept_pw;
        evt[MI_WRITE_MISS] = port_stat.tx_write_miss;
        evt[MI_READ_MISS]  = port_stat.tx_read_miss;
        clr = (wr && hit(a, OFS_INT_FLAGS)) ? wd[6:0] : 7'h00;
        for (int i = 0; i < 7; i++) begin
            state_next.int_flags[i] = MI_USED_MASK[i] & w1c(state_reg.int_flags[i], evt[i], clr[i]);
        end

        // read answer, registered, unmapped reads zero
        // data is zero outside the answer cycle
        state_next.rvalid = reg_req.rd;
        state_next.rdata  = reg_req.rd ? read_word(state_reg, port_stat, a) : 32'h0000_0000;
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg              <= '0;
            state_reg.small_id     <= SMALL_ID_RST;
            state_reg.host_id      <= HOST_ID_RST;
            state_reg.label        <= LABEL_RST;
            state_reg.link_to      <= TIMEOUT_RST;
            state_reg.resp_to      <= TIMEOUT_RST;
            state_reg.lane_ovr     <= OVERRIDE_RST;
            state_reg.tx_en        <= 1'b1;
            state_reg.rx_en        <= 1'b1;
            state_reg.pw_accept    <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    always_comb begin
        reg_resp.rvalid = state_reg.rvalid;
        reg_resp.rdata  = state_reg.rdata;
        port_ctrl.small_system_identifier = state_reg.small_id;
        port_ctrl.host_identifier         = state_reg.host_id;
        port_ctrl.link_timeout            = state_reg.link_to;
        port_ctrl.resp_timeout            = state_reg.resp_to;
        port_ctrl.host_role               = state_reg.host_role;
        port_ctrl.request_issue_permit    = state_reg.req_permit;
        port_ctrl.lane_override           = state_reg.lane_ovr;
        port_ctrl.port_shutdown           = state_reg.shutdown;
        port_ctrl.tx_issue_enable         = state_reg.tx_en;
        port_ctrl.rx_accept_enable        = state_reg.rx_en;
        port_ctrl.error_check_off         = state_reg.chk_off;
        port_ctrl.force_reinit            = state_reg.force_reinit;
        port_ctrl.pw_store                = state_reg.pw_store;
        port_ctrl.pw_drop                 = state_reg.pw_drop;
        mnt_irq = |(state_reg.int_flags & state_reg.int_en);
    end

endmodule

// *** common/rsp_csr_pkg.sv ***
// package with offsets, field positions, reset values and carrier types of the serial port register bank
package rsp_csr_pkg;

    // register byte offsets
    localparam logic [16:0] OFS_CFG_BASE0     = 17'h0_0058; // local config base, low half
    localparam logic [16:0] OFS_CFG_BASE1     = 17'h0_005c; // local config base, high half
    localparam logic [16:0] OFS_BASE_ID       = 17'h0_0060; // base_identifier
    localparam logic [16:0] OFS_HOST_LOCK     = 17'h0_0068; // host_identifier_lock
    localparam logic [16:0] OFS_COMP_LABEL    = 17'h0_006c; // component_label
    localparam logic [16:0] OFS_FEAT_HDR      = 17'h0_0100; // serial_feature_header
    localparam logic [16:0] OFS_LINK_TO       = 17'h0_0120; // link_timeout_value
    localparam logic [16:0] OFS_RESP_TO       = 17'h0_0124; // response_timeout_value
    localparam logic [16:0] OFS_GEN_CTRL      = 17'h0_013c; // port_general_control
    localparam logic [16:0] OFS_ERR_STAT      = 17'h0_0158; // port_error_status
    localparam logic [16:0] OFS_LANE_CTRL     = 17'h0_015c; // port_lane_control
    localparam logic [16:0] OFS_INT_FLAGS     = 17'h1_0080; // maintenance_interrupt_flags
    localparam logic [16:0] OFS_INT_ENABLE    = 17'h1_0084; // interrupt enables
    localparam logic [16:0] OFS_PW_CTRL       = 17'h1_0250; // port-write receive control

    // fixed read values
    localparam logic [15:0] LARGE_ID_VALUE    = 16'hffff;
    localparam logic [15:0] NEXT_BLOCK_PTR    = 16'h0000;
    localparam logic [15:0] FEATURE_BLOCK_ID  = 16'h0001;
    localparam logic [1:0]  LANE_CAPACITY     = 2'b01;   // four-lane build

    // reset values
    localparam logic [7:0]  SMALL_ID_RST      = 8'hff;
    localparam logic [15:0] HOST_ID_RST       = 16'hffff;
    localparam logic [31:0] LABEL_RST         = 32'h0000_0000;
    localparam logic [23:0] TIMEOUT_RST       = 24'h0f_ffff;
    localparam logic [2:0]  OVERRIDE_RST      = 3'b000;

    // lane override codes
    localparam logic [2:0]  OVR_NONE          = 3'b000;
    localparam logic [2:0]  OVR_LANE0         = 3'b010;
    localparam logic [2:0]  OVR_LANE2         = 3'b011;

    // general control bit positions
    localparam int GC_HOST      = 31;
    localparam int GC_PERMIT    = 30;
    localparam int GC_DISCOVER  = 29;

    // error/status bit positions
    localparam int ES_OUT_RTY_SEEN  = 20;
    localparam int ES_OUT_RTY_STUCK = 19;
    localparam int ES_OUT_RTY_HALT  = 18;
    localparam int ES_OUT_ERR_SEEN  = 17;
    localparam int ES_OUT_ERR_HALT  = 16;
    localparam int ES_IN_RTY_HALT   = 10;
    localparam int ES_IN_ERR_SEEN   = 9;
    localparam int ES_IN_ERR_HALT   = 8;
    localparam int ES_FATAL         = 2;
    localparam int ES_LINK_OK       = 1;
    localparam int ES_TRAINING      = 0;

    // lane control bit positions
    localparam int LC_CAP_LSB     = 30;
    localparam int LC_TRAINED_LSB = 27;
    localparam int LC_OVR_LSB     = 24;
    localparam int LC_SHUTDOWN    = 23;
    localparam int LC_TX_EN       = 22;
    localparam int LC_RX_EN       = 21;
    localparam int LC_CHK_OFF     = 20;
    localparam int LC_MULTICAST   = 19;
    localparam int LC_SERIAL      = 0;

    // maintenance interrupt bit positions
    localparam int MI_PW_ERROR    = 6;
    localparam int MI_PW_DROPPED  = 5;
    localparam int MI_PW_STORED   = 4;
    localparam int MI_WRITE_MISS  = 1;
    localparam int MI_READ_MISS   = 0;
    localparam logic [6:0] MI_USED_MASK = 7'h73;

    localparam int PW_ACCEPT_BIT  = 0;

    // register port request
    typedef struct packed {
        logic        wr;     // write strobe
        logic        rd;     // read strobe
        logic [16:0] addr;   // byte address
        logic [31:0] wdata;  // write data
    } rsp_req_t;

    // register port answer
    typedef struct packed {
        logic        rvalid; // read data valid, one cycle
        logic [31:0] rdata;  // read data
    } rsp_resp_t;

    // link and port-write events and live states from the port logic
    typedef struct packed {
        logic       out_retry_evt;
        logic       out_error_evt;
        logic       in_error_evt;
        logic       fatal_evt;
        logic       out_retry_stuck;
        logic       out_retry_halt;
        logic       out_error_halt;
        logic       in_retry_halt;
        logic       in_error_halt;
        logic       link_ok;
        logic       link_training;
        logic [2:0] trained_width;
        logic       pw_arrive;
        logic       pw_read_done;
        logic       pw_error_evt;
        logic       tx_write_miss;
        logic       tx_read_miss;
    } rsp_stat_t;

    // controls driven to the port logic
    typedef struct packed {
        logic [7:0]  small_system_identifier;
        logic [15:0] host_identifier;
        logic [23:0] link_timeout;
        logic [23:0] resp_timeout;
        logic        host_role;
        logic        request_issue_permit;
        logic [2:0]  lane_override;
        logic        port_shutdown;
        logic        tx_issue_enable;
        logic        rx_accept_enable;
        logic        error_check_off;
        logic        force_reinit;
        logic        pw_store;
        logic        pw_drop;
    } rsp_ctrl_t;

endpackage

// *** verification/rsp_port_model.sv ***
// behavioural port logic that feeds events and link states to the bank
`timescale 1ns/1ps
module rsp_port_model
    import rsp_csr_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst_n,
    input  wire rsp_stat_t kick,
    input  wire rsp_ctrl_t port_ctrl,
    output rsp_stat_t      port_stat
);
    logic [4:0] train_cnt_reg; // training cycles left
    // link trains after reset and after every forced reinit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            train_cnt_reg <= 5'h14;
        end else if (port_ctrl.force_reinit) begin
            train_cnt_reg <= 5'h14;
        end else if (train_cnt_reg != 5'h0) begin
            train_cnt_reg <= train_cnt_reg - 5'h1;
        end
    end
    // event pulses and halt levels from the bench, link levels from the training state
    always_comb begin
        port_stat = kick;
        port_stat.link_training = (train_cnt_reg != 5'h0);
        port_stat.link_ok = (train_cnt_reg == 5'h0);
        port_stat.trained_width = 3'b010; // four lanes
    end
endmodule

// *** verification/rsp_csr_bank_checker.sv ***
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module rsp_csr_bank_checker
    import rsp_csr_pkg::*;
(
    input wire logic      core_clk,
    input wire logic      rst_n,
    input wire rsp_req_t  reg_req,
    input wire rsp_resp_t reg_resp,
    input wire rsp_stat_t port_stat,
    input wire rsp_ctrl_t port_ctrl,
    input wire logic      mnt_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    cfg_base_zero_a: assert property (reg_req.rd && (reg_req.addr == OFS_CFG_BASE0 || reg_req.addr == OFS_CFG_BASE1) |=>
        reg_resp.rdata == 32'h0)
        else $error("config base not zero");
    large_id_fixed_a: assert property (reg_req.rd && reg_req.addr == OFS_BASE_ID |=>
        reg_resp.rvalid && reg_resp.rdata[15:0] == LARGE_ID_VALUE) else $error("large id wrong");
    feature_header_a: assert property (reg_req.rd && reg_req.addr == OFS_FEAT_HDR |=>
        reg_resp.rdata == {NEXT_BLOCK_PTR, FEATURE_BLOCK_ID}) else $error("feature header wrong");
    timeout_low_a: assert property (reg_req.rd && reg_req.addr == OFS_LINK_TO |=> reg_resp.rdata[7:0] == 8'h0)
        else $error("time-out low byte set");
    fatal_stop_a: assert property (port_stat.fatal_evt && !port_ctrl.error_check_off |=>
        !port_ctrl.tx_issue_enable && !port_ctrl.rx_accept_enable) else $error("enables kept after fatal");
    link_state_a: assert property (reg_req.rd && reg_req.addr == OFS_ERR_STAT |=> !reg_resp.rdata[4] &&
        reg_resp.rdata[1:0] == {$past(port_stat.link_ok), $past(port_stat.link_training)}) else $error("link state wrong");
    lane_width_a: assert property (reg_req.rd && reg_req.addr == OFS_LANE_CTRL |=>
        reg_resp.rdata[31:27] == {LANE_CAPACITY, $past(port_stat.trained_width)}) else $error("lane width wrong");
    reinit_pulse_a: assert property (port_ctrl.force_reinit == $fell(port_ctrl.port_shutdown))
        else $error("reinit pulse wrong");
    pw_verdict_a: assert property (port_stat.pw_arrive |=> port_ctrl.pw_store != port_ctrl.pw_drop)
        else $error("port-write not decided");
endmodule
bind rsp_csr_bank rsp_csr_bank_checker i_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_resp(reg_resp), .port_stat(port_stat), .port_ctrl(port_ctrl), .mnt_irq(mnt_irq));

// *** verification/rsp_csr_bank_test.sv ***
// self-checking bench of the serial port register bank
`timescale 1ns/1ps
module rsp_csr_bank_test;
    import rsp_csr_pkg::*;
    logic      core_clk = 1'b0; // 50 MHz clock
    logic      rst_n = 1'b0; // async reset
    rsp_req_t  req = '0; // register requests
    rsp_resp_t resp; // read answers
    rsp_stat_t kick = '0; // event pulses
    rsp_stat_t stat; // model to bank
    rsp_ctrl_t ctrl; // bank controls
    logic      irq; // interrupt line
    int        n_errors = 0;
    int        total_checks = 0;
    always #10 core_clk = ~core_clk;
    rsp_csr_bank i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .reg_resp(resp),
        .port_stat(stat), .port_ctrl(ctrl), .mnt_irq(irq));
    rsp_port_model i_port (.core_clk(core_clk), .rst_n(rst_n), .kick(kick), .port_ctrl(ctrl), .port_stat(stat));
    // compare and count
    task automatic check(logic [32:0] got, logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one register write
    task automatic wr(logic [16:0] a, logic [31:0] d);
        @(posedge core_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge core_clk);
        req.wr <= 1'b0;
        #1;
    endtask
    // one register read, answer expected the next cycle
    task automatic rd(logic [16:0] a, logic [31:0] exp, logic [31:0] m = 32'hffff_ffff);
        @(posedge core_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        check({resp.rvalid, resp.rdata & m}, {1'b1, exp});
    endtask
    // one-cycle event from the port side
    task automatic ev(rsp_stat_t e);
        @(posedge core_clk);
        kick <= e;
        @(posedge core_clk);
        kick <= '0;
        #1;
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(OFS_ERR_STAT, 32'h0000_0001);
        rd(OFS_CFG_BASE1, 32'h0);
        rd(OFS_BASE_ID, 32'h00ff_ffff);
        rd(OFS_HOST_LOCK, 32'h0000_ffff);
        rd(OFS_COMP_LABEL, 32'h0);
        rd(OFS_FEAT_HDR, 32'h0000_0001);
        rd(OFS_RESP_TO, 32'h0fff_ff00);
        rd(OFS_GEN_CTRL, 32'h0);
        rd(OFS_LANE_CTRL, 32'h5060_0001);
        rd(OFS_INT_ENABLE, 32'h0);
        rd(OFS_PW_CTRL, 32'h0000_0001);
        wr(17'h0_0200, 32'hffff_ffff);
        rd(17'h0_0200, 32'h0);
        wr(OFS_BASE_ID, 32'h1234_5678);
        rd(OFS_BASE_ID, 32'h0034_ffff);
        check(33'(ctrl.small_system_identifier), 33'h34);
        wr(OFS_HOST_LOCK, 32'h0000_abcd);
        wr(OFS_HOST_LOCK, 32'h0000_1111);
        rd(OFS_HOST_LOCK, 32'h0000_abcd);
        check(33'(ctrl.host_identifier), 33'h0_abcd);
        wr(OFS_COMP_LABEL, 32'ha5a5_5a5a);
        rd(OFS_COMP_LABEL, 32'ha5a5_5a5a);
        wr(OFS_LINK_TO, 32'hffff_ffff);
        rd(OFS_LINK_TO, 32'hffff_ff00);
        check(33'(ctrl.link_timeout), 33'h0ff_ffff);
        check(33'(ctrl.resp_timeout), 33'h00f_ffff);
        wr(OFS_GEN_CTRL, 32'hffff_ffff);
        rd(OFS_GEN_CTRL, 32'he000_0000);
        check(33'({ctrl.host_role, ctrl.request_issue_permit}), 33'h3);
        wr(OFS_LANE_CTRL, 32'h0360_0000);
        wr(OFS_LANE_CTRL, 32'h0560_0000);
        rd(OFS_LANE_CTRL, 32'h5360_0001);
        check(33'(ctrl.lane_override), 33'h3);
        wr(OFS_LANE_CTRL, 32'h00e0_0000);
        check(33'(ctrl.port_shutdown), 33'h1);
        wr(OFS_LANE_CTRL, 32'h0060_0000);
        rd(OFS_ERR_STAT, 32'h0000_0001, 32'h0000_0003);
        repeat (24) @(posedge core_clk);
        ev('{out_retry_evt: 1'b1, out_error_evt: 1'b1, in_error_evt: 1'b1, default: '0});
        rd(OFS_ERR_STAT, 32'h0012_0202);
        wr(OFS_ERR_STAT, 32'h0);
        rd(OFS_ERR_STAT, 32'h0012_0202);
        wr(OFS_ERR_STAT, 32'h0012_0200);
        rd(OFS_ERR_STAT, 32'h0000_0002);
        wr(OFS_LANE_CTRL, 32'h0070_0000);
        check(33'(ctrl.error_check_off), 33'h1);
        ev('{out_error_evt: 1'b1, default: '0});
        rd(OFS_ERR_STAT, 32'h0000_0002);
        @(posedge core_clk);
        kick <= '{out_retry_stuck: 1'b1, out_retry_halt: 1'b1, out_error_halt: 1'b1, in_retry_halt: 1'b1,
                  in_error_halt: 1'b1, default: '0};
        rd(OFS_ERR_STAT, 32'h000d_0502);
        @(posedge core_clk);
        kick <= '0;
        wr(OFS_LANE_CTRL, 32'h0060_0000);
        ev('{fatal_evt: 1'b1, default: '0});
        check(33'({ctrl.tx_issue_enable, ctrl.rx_accept_enable}), 33'h0);
        rd(OFS_ERR_STAT, 32'h0000_0006);
        wr(OFS_INT_ENABLE, 32'h0000_0073);
        ev('{pw_arrive: 1'b1, default: '0});
        check(33'({ctrl.pw_store, irq}), 33'h3);
        ev('{pw_arrive: 1'b1, default: '0});
        check(33'(ctrl.pw_drop), 33'h1);
        rd(OFS_INT_FLAGS, 32'h0000_0030);
        ev('{pw_read_done: 1'b1, default: '0});
        wr(OFS_INT_FLAGS, 32'h0000_0030);
        check(33'(irq), 33'h0);
        wr(OFS_PW_CTRL, 32'h0);
        ev('{pw_arrive: 1'b1, default: '0});
        check(33'(ctrl.pw_drop), 33'h1);
        ev('{tx_write_miss: 1'b1, tx_read_miss: 1'b1, pw_error_evt: 1'b1, default: '0});
        rd(OFS_INT_FLAGS, 32'h0000_0063);
        fork
            wr(OFS_INT_FLAGS, 32'h0000_0040);
            ev('{pw_error_evt: 1'b1, default: '0});
        join
        rd(OFS_INT_FLAGS, 32'h0000_0063);
        wr(OFS_INT_ENABLE, 32'h0);
        check(33'(irq), 33'h0);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        wr(OFS_HOST_LOCK, 32'h0000_1111);
        rd(OFS_HOST_LOCK, 32'h0000_1111);
        report_and_stop();
    end
endmodule
